/* rfs_supervisor.sv */
// rail fault supervisor: status, thresholds, overrides, hiccup and latch-off
//
// Summary of operation
// - warning comparator sets warning status bit and pulls alert low
// - warning threshold codes reset to the default levels
// - warning threshold codes are writable three-bit fields
// - warning response override bits live in two control registers
// - overrides act only while the global override enable bit is one
// - limit comparator sets limit status, pulls alert, enters mode-pin response
// - limit response choice is overridable by two control registers
// - hiccup stops main converter, keeps aux, restarts soft-start after wait
// - latch-off stops main converter, keeps aux, holds until an enable toggles
// - run enable toggle in latch-off restarts main converter from soft-start
// - chip enable toggle in latch-off drops aux supplies once then full initialisation
// - limit threshold codes reset to the default levels
// - overvoltage limit threshold codes are writable three-bit fields
// - both levels apply to input and output case of both rails
`timescale 1ns/1ps
module rfs_supervisor #(
    parameter int P_HICCUP_CYC = rfs_pkg::RFS_HICCUP_CYC
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_sys_rst,
    input  wire rfs_pkg::rfs_reg_req_t i_reg,
    output logic [7:0]                o_reg_rdata,
    output logic                      o_reg_rack,
    input  wire rfs_pkg::rfs_rail_t   i_warn_cmp,
    input  wire rfs_pkg::rfs_rail_t   i_limit_cmp,
    input  wire logic                 i_mode_latch,
    input  wire logic                 i_run_enable,
    input  wire logic                 i_chip_enable,
    output rfs_pkg::rfs_thresh_t      o_thresh,
    output logic                      o_fault_alert_n,
    output logic                      o_main_run,
    output logic                      o_soft_start,
    output logic                      o_aux_run,
    output logic                      o_full_init
);
    import rfs_pkg::*;

    typedef struct packed {
        rfs_state_t  state;
        logic [31:0] hic_cnt;
        logic        ovr_en;
        logic [7:0]  wrn_a;
        logic [7:0]  wrn_b;
        logic [7:0]  lim_a;
        logic [7:0]  lim_b;
        rfs_thresh_t th;
        logic [7:0]  rdata;
        logic        rack;
        logic        alert_n;
        logic        main_run;
        logic        soft_start;
        logic        aux_run;
        logic        full_init;
    } rfs_main_st_t;

    localparam rfs_thresh_t RFS_TH_RST = '{
        lo_ov_wrn: RFS_LO_OV_WRN_RST,
        lo_uv_wrn: RFS_LO_UV_WRN_RST,
        hi_ov_wrn: RFS_HI_OV_WRN_RST,
        hi_uv_wrn: RFS_HI_UV_WRN_RST,
        lo_ov_lim: RFS_LO_OV_LIM_RST,
        hi_ov_lim: RFS_HI_OV_LIM_RST
    };
    localparam logic [31:0] RFS_HIC_LAST = 32'(P_HICCUP_CYC - 1);

    rfs_main_st_t q;
    rfs_main_st_t d;
    logic [7:0]   wrn_flags;
    logic [7:0]   lim_flags;
    logic [7:0]   wrn_clr;
    logic [7:0]   lim_clr;
    logic [7:0]   wrn_act;
    logic [1:0]   lim_resp;
    logic [1:0]   wrn_resp;

    // ==========================================================
    // response selection: {trip, latch}; latch-off wins over hiccup
    function automatic logic [1:0] rfs_resp(
        input logic [7:0] act,
        input logic [7:0] sel,
        input logic [7:0] val,
        input logic       mode
    );
        logic l;
        l = |(act & ((sel & val) | (~sel & {8{mode}})));
        return {|act, l};
    endfunction

    // ==========================================================
    // status flags
    always_comb
    begin
        wrn_clr = '0;
        lim_clr = '0;
        if (i_reg.wr && i_reg.addr == RFS_OFS_WRN_STAT)
        begin
            wrn_clr = i_reg.wdata;
        end
        if (i_reg.wr && i_reg.addr == RFS_OFS_LIM_STAT)
        begin
            lim_clr = i_reg.wdata;
        end
    end

    rfs_sticky_status #(
        .P_W (8)
    ) u_wrn_stat (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (i_warn_cmp),
        .i_clr     (wrn_clr),
        .o_flags   (wrn_flags)
    );

    rfs_sticky_status #(
        .P_W (8)
    ) u_lim_stat (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (i_limit_cmp),
        .i_clr     (lim_clr),
        .o_flags   (lim_flags)
    );

    // ==========================================================
    // fault response decision
    always_comb
    begin
        // warnings only escalate when software asked for it
        wrn_act  = i_warn_cmp & q.wrn_a & {8{q.ovr_en}};
        wrn_resp = rfs_resp(wrn_act, wrn_act, q.wrn_b, 1'b0);
        lim_resp = rfs_resp(i_limit_cmp, q.lim_a & {8{q.ovr_en}}, q.lim_b,
                            i_mode_latch);
    end

    // ==========================================================
    // next state
    always_comb
    begin
        d            = q;
        d.rack       = 1'b0;
        d.soft_start = 1'b0;
        d.full_init  = 1'b0;

        // register writes
        if (i_reg.wr)
        begin
            case (i_reg.addr)
                RFS_OFS_OVR_EN:  d.ovr_en = i_reg.wdata[RFS_OVR_EN_BIT];
                RFS_OFS_WRN_A:   d.wrn_a = i_reg.wdata;
                RFS_OFS_WRN_B:   d.wrn_b = i_reg.wdata;
                RFS_OFS_LIM_A:   d.lim_a = i_reg.wdata;
                RFS_OFS_LIM_B:   d.lim_b = i_reg.wdata;
                RFS_OFS_LOW_OV:
                begin
                    d.th.lo_ov_wrn = i_reg.wdata[RFS_WRN_LSB +: RFS_TH_W];
                    d.th.lo_ov_lim = i_reg.wdata[RFS_LIM_LSB +: RFS_TH_W];
                end
                RFS_OFS_UV_WRN:
                begin
                    d.th.lo_uv_wrn = i_reg.wdata[RFS_WRN_LSB +: RFS_TH_W];
                    d.th.hi_uv_wrn = i_reg.wdata[RFS_HUV_LSB +: RFS_TH_W];
                end
                RFS_OFS_HIGH_OV:
                begin
                    d.th.hi_ov_wrn = i_reg.wdata[RFS_WRN_LSB +: RFS_TH_W];
                    d.th.hi_ov_lim = i_reg.wdata[RFS_LIM_LSB +: RFS_TH_W];
                end
                default:
                begin
                end
            endcase
        end

        // register reads; unmapped offsets answer zero
        if (i_reg.rd)
        begin
            d.rack = 1'b1;
            case (i_reg.addr)
                RFS_OFS_OVR_EN:   d.rdata = {q.ovr_en, 7'h00};
                RFS_OFS_WRN_A:    d.rdata = q.wrn_a;
                RFS_OFS_WRN_B:    d.rdata = q.wrn_b;
                RFS_OFS_LIM_A:    d.rdata = q.lim_a;
                RFS_OFS_LIM_B:    d.rdata = q.lim_b;
                RFS_OFS_LOW_OV:   d.rdata = {2'h0, q.th.lo_ov_lim, q.th.lo_ov_wrn};
                RFS_OFS_UV_WRN:   d.rdata = {2'h0, q.th.hi_uv_wrn, q.th.lo_uv_wrn};
                RFS_OFS_HIGH_OV:  d.rdata = {2'h0, q.th.hi_ov_lim, q.th.hi_ov_wrn};
                RFS_OFS_WRN_STAT: d.rdata = wrn_flags;
                RFS_OFS_LIM_STAT: d.rdata = lim_flags;
                default:          d.rdata = 8'h00;
            endcase
        end

        // alert follows live comparators too, so it drops with the flag
        d.alert_n = ~((|wrn_flags) | (|lim_flags) | (|i_warn_cmp) | (|i_limit_cmp));

        // protection sequencing
        case (q.state)
            RFS_RUN:
            begin
                d.main_run = 1'b1;
                d.aux_run  = 1'b1;
                if (lim_resp[1] || wrn_resp[1])
                begin
                    d.main_run = 1'b0;
                    d.hic_cnt  = '0;
                    if (lim_resp[0] || wrn_resp[0])
                    begin
                        d.state = RFS_LATCH;
                    end
                    else
                    begin
                        d.state = RFS_HICCUP;
                    end
                end
            end
            RFS_HICCUP:
            begin
                // aux supplies stay up so the controller keeps power
                d.main_run = 1'b0;
                d.aux_run  = 1'b1;
                d.hic_cnt  = q.hic_cnt + 32'h1;
                if (q.hic_cnt == RFS_HIC_LAST)
                begin
                    d.state      = RFS_RUN;
                    d.main_run   = 1'b1;
                    d.soft_start = 1'b1;
                end
            end
            RFS_LATCH:
            begin
                d.main_run = 1'b0;
                d.aux_run  = 1'b1;
                if (!i_chip_enable)
                begin
                    d.state   = RFS_CHIP_OFF;
                    d.aux_run = 1'b0;
                end
                else if (!i_run_enable)
                begin
                    d.state = RFS_PWM_OFF;
                end
            end
            RFS_PWM_OFF:
            begin
                d.main_run = 1'b0;
                d.aux_run  = 1'b1;
                if (!i_chip_enable)
                begin
                    d.state   = RFS_CHIP_OFF;
                    d.aux_run = 1'b0;
                end
                else if (i_run_enable)
                begin
                    d.state      = RFS_RUN;
                    d.main_run   = 1'b1;
                    d.soft_start = 1'b1;
                end
            end
            RFS_CHIP_OFF:
            begin
                d.main_run = 1'b0;
                d.aux_run  = 1'b0;
                if (i_chip_enable)
                begin
                    d.state     = RFS_RUN;
                    d.aux_run   = 1'b1;
                    d.main_run  = 1'b1;
                    d.full_init = 1'b1;
                end
            end
            default:
            begin
                d.state = RFS_RUN;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            q            <= '0;
            q.state      <= RFS_RUN;
            q.wrn_a      <= RFS_CTRL_RST;
            q.wrn_b      <= RFS_CTRL_RST;
            q.lim_a      <= RFS_CTRL_RST;
            q.lim_b      <= RFS_CTRL_RST;
            q.th         <= RFS_TH_RST;
            q.alert_n    <= 1'b1;
            q.main_run   <= 1'b1;
            q.aux_run    <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_reg_rdata     = q.rdata;
    assign o_reg_rack      = q.rack;
    assign o_thresh        = q.th;
    assign o_fault_alert_n = q.alert_n;
    assign o_main_run      = q.main_run;
    assign o_soft_start    = q.soft_start;
    assign o_aux_run       = q.aux_run;
    assign o_full_init     = q.full_init;

    // ==========================================================
    // checks
    warn_alert_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (|i_warn_cmp) |=> (!o_fault_alert_n && ((wrn_flags & $past(i_warn_cmp)) == $past(i_warn_cmp))))
        else $error("warning did not flag or alert");

    limit_alert_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (|i_limit_cmp) |=> (!o_fault_alert_n && ((lim_flags & $past(i_limit_cmp)) == $past(i_limit_cmp))))
        else $error("limit did not flag or alert");

    alert_release_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (wrn_flags == 8'h00 && lim_flags == 8'h00 && i_warn_cmp == 8'h00 && i_limit_cmp == 8'h00)
        |=> o_fault_alert_n)
        else $error("alert held with nothing pending");

    thresh_reset_a: assert property (@(posedge i_ref_clk)
        i_sys_rst |=> (o_thresh == RFS_TH_RST))
        else $error("thresholds not at reset levels");

    ovr_gated_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (q.state == RFS_RUN && (|i_limit_cmp) && !q.ovr_en && !i_mode_latch)
        |=> (q.state == RFS_HICCUP && !o_main_run))
        else $error("override honoured while disabled");

    hiccup_keep_aux_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (q.state == RFS_HICCUP) |-> (!o_main_run && o_aux_run))
        else $error("hiccup lost aux or kept main");

    latch_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (q.state == RFS_LATCH && i_run_enable && i_chip_enable)
        |=> (q.state == RFS_LATCH && !o_main_run && o_aux_run))
        else $error("latch-off left without a toggle");

    run_restart_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (q.state == RFS_PWM_OFF && i_run_enable && i_chip_enable)
        |=> (o_soft_start && o_main_run && o_aux_run && !o_full_init))
        else $error("run enable restart wrong");

    chip_restart_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (q.state == RFS_CHIP_OFF && !i_chip_enable) ##1 i_chip_enable
        |=> (o_full_init && o_aux_run) ##1 !o_full_init)
        else $error("chip enable restart wrong");

endmodule // rfs_supervisor

/* rfs_pkg.sv */
// constants, types and register map of the rail fault supervisor
package rfs_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] RFS_OFS_OVR_EN   = 8'hb0;
    localparam logic [7:0] RFS_OFS_WRN_A    = 8'hb1;
    localparam logic [7:0] RFS_OFS_WRN_B    = 8'hb2;
    localparam logic [7:0] RFS_OFS_LIM_A    = 8'hb7;
    localparam logic [7:0] RFS_OFS_LIM_B    = 8'hb8;
    localparam logic [7:0] RFS_OFS_LOW_OV   = 8'hb9;
    localparam logic [7:0] RFS_OFS_UV_WRN   = 8'hba;
    localparam logic [7:0] RFS_OFS_HIGH_OV  = 8'hbb;
    localparam logic [7:0] RFS_OFS_WRN_STAT = 8'hd2;
    localparam logic [7:0] RFS_OFS_LIM_STAT = 8'hd7;

    // ==========================================================
    // field positions
    localparam int RFS_OVR_EN_BIT = 7;
    localparam int RFS_TH_W       = 3;
    localparam int RFS_WRN_LSB    = 0;
    localparam int RFS_LIM_LSB    = 3;
    localparam int RFS_HUV_LSB    = 3;

    // ==========================================================
    // reset values; code zero selects the factory level
    localparam logic [2:0] RFS_LO_OV_WRN_RST = 3'h0; // 115 percent of target
    localparam logic [2:0] RFS_LO_UV_WRN_RST = 3'h0; // 85 percent of target
    localparam logic [2:0] RFS_HI_OV_WRN_RST = 3'h0; // 108 percent of target
    localparam logic [2:0] RFS_HI_UV_WRN_RST = 3'h0; // 75 percent of target
    localparam logic [2:0] RFS_LO_OV_LIM_RST = 3'h0; // 150 percent of target
    localparam logic [2:0] RFS_HI_OV_LIM_RST = 3'h0; // 125 percent of target
    localparam logic [7:0] RFS_CTRL_RST      = 8'h00;

    // ==========================================================
    // timing
    localparam int RFS_CLK_KHZ    = 250000;
    localparam int RFS_HICCUP_MS  = 500;
    localparam int RFS_HICCUP_CYC = RFS_HICCUP_MS * RFS_CLK_KHZ;

    // ==========================================================
    // types
    typedef struct packed {
        logic hi_uv_out;
        logic hi_uv_in;
        logic hi_ov_out;
        logic hi_ov_in;
        logic lo_uv_out;
        logic lo_uv_in;
        logic lo_ov_out;
        logic lo_ov_in;
    } rfs_rail_t;

    typedef struct packed {
        logic [2:0] lo_ov_wrn;
        logic [2:0] lo_uv_wrn;
        logic [2:0] hi_ov_wrn;
        logic [2:0] hi_uv_wrn;
        logic [2:0] lo_ov_lim;
        logic [2:0] hi_ov_lim;
    } rfs_thresh_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfs_reg_req_t;

    typedef enum logic [2:0] {
        RFS_RUN      = 3'b000,
        RFS_HICCUP   = 3'b001,
        RFS_LATCH    = 3'b010,
        RFS_PWM_OFF  = 3'b011,
        RFS_CHIP_OFF = 3'b100
    } rfs_state_t;

endpackage

/* rfs_sticky_status.sv */
// sticky status flags with write-one-to-clear, set beats clear
`timescale 1ns/1ps
module rfs_sticky_status #(
    parameter int P_W = 8
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_sys_rst,
    input  wire logic [P_W-1:0] i_set,
    input  wire logic [P_W-1:0] i_clr,
    output logic      [P_W-1:0] o_flags
);
    import rfs_pkg::*;

    typedef struct packed {
        logic [P_W-1:0] flags;
    } rfs_sticky_st_t;

    rfs_sticky_st_t q;
    rfs_sticky_st_t d;

    // ==========================================================
    // next state
    always_comb
    begin
        d = q;
        // an event landing on the clear cycle survives
        d.flags = (q.flags & ~i_clr) | i_set;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_flags = q.flags;

    // ==========================================================
    // checks
    set_beats_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (|(i_set & i_clr)) |=> ((o_flags & $past(i_set)) == $past(i_set)))
        else $error("flag set during clear was lost");

    flag_holds_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_set == '0 && i_clr == '0) |=> (o_flags == $past(o_flags)))
        else $error("flag changed without set or clear");

endmodule // rfs_sticky_status

/* rfs_host_model.sv */
// partner model: system controller on the register port
`timescale 1ns/1ps
module rfs_host_model (
    input  wire logic          i_ref_clk,
    input  wire logic          i_fault_alert_n,
    input  wire logic [7:0]    i_rdata,
    input  wire logic          i_rack,
    output rfs_pkg::rfs_reg_req_t o_reg
);
    import rfs_pkg::*;
    // ==========
    // idle bus shows inverted last values, never a stale copy
    initial o_reg = '0;
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_reg = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_ref_clk);
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask
    // plain byte read; data and acknowledge taken while they stand
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic k);
        put(1'b0, a, 8'h00);
        d = i_rdata;
        k = i_rack;
    endtask
    // fetch the cause once the alert has been seen, bounded wait
    task automatic on_alert(input int lim, output logic [7:0] d, output logic k);
        int n;
        n = 0;
        while (n < lim && i_fault_alert_n !== 1'b0)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        rd(RFS_OFS_WRN_STAT, d, k);
        // no alert seen: report no acknowledge so the caller flags it
        if (n >= lim)
        begin
            k = 1'b0;
        end
    endtask
endmodule // rfs_host_model

/* tb_rfs_supervisor.sv */
// self-checking testbench of the rail fault supervisor
`timescale 1ns/1ps
module tb_rfs_supervisor;
    import rfs_pkg::*;
    localparam int HC = 20;
    logic         i_ref_clk, i_sys_rst, i_mode_latch, i_run_enable, i_chip_enable;
    rfs_reg_req_t i_reg;
    rfs_rail_t    i_warn_cmp, i_limit_cmp;
    rfs_thresh_t  o_thresh;
    logic [7:0]   o_reg_rdata;
    logic         o_reg_rack, o_fault_alert_n, o_main_run, o_soft_start, o_aux_run;
    logic         o_full_init;
    int           err_count = 0;
    int           checked = 0;
    // ==========
    // short hiccup so the run stays brief
    rfs_supervisor #(.P_HICCUP_CYC(HC)) dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_reg_rack(o_reg_rack),
        .i_warn_cmp(i_warn_cmp), .i_limit_cmp(i_limit_cmp), .i_mode_latch(i_mode_latch),
        .i_run_enable(i_run_enable), .i_chip_enable(i_chip_enable), .o_thresh(o_thresh),
        .o_fault_alert_n(o_fault_alert_n), .o_main_run(o_main_run),
        .o_soft_start(o_soft_start), .o_aux_run(o_aux_run), .o_full_init(o_full_init));
    rfs_host_model host (.i_ref_clk(i_ref_clk), .i_fault_alert_n(o_fault_alert_n),
        .i_rdata(o_reg_rdata), .i_rack(o_reg_rack), .o_reg(i_reg));
    // ==========
    // helpers
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic       k;
        host.rd(a, d, k);
        chk("rack", 18'h1, 18'(k));
        chk(nm, 18'(e), 18'(d));
    endtask
    // bounded wait for soft start (s=0) or full init (s=1)
    task automatic pulse(input bit s, input int lim, output int n);
        n = 0;
        while (n < lim && !(s ? o_full_init === 1'b1 : o_soft_start === 1'b1))
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic trip(input int i, input logic m);
        i_mode_latch = m;
        i_limit_cmp = rfs_rail_t'(8'h01 << i);
        cyc(1);
        i_limit_cmp = '0;
    endtask
    task automatic run_toggle;
        i_run_enable = 1'b0;
        cyc(2);
        i_run_enable = 1'b1;
        cyc(3);
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        chk("thresh", 18'h0, o_thresh);
        chk("alert", 18'h1, 18'(o_fault_alert_n));
        rdc(RFS_OFS_WRN_STAT, 8'h00, "warn_stat");
        rdc(8'hc0, 8'h00, "unmapped");
        host.wr(RFS_OFS_OVR_EN, 8'hff);
        rdc(RFS_OFS_OVR_EN, 8'h80, "ovr_en");
        host.wr(RFS_OFS_OVR_EN, 8'h00);
    endtask
    task automatic t_thresh;
        host.wr(RFS_OFS_LOW_OV, 8'h2b);
        host.wr(RFS_OFS_UV_WRN, 8'h3e);
        host.wr(RFS_OFS_HIGH_OV, 8'h11);
        chk("thresh", {3'h3, 3'h6, 3'h1, 3'h7, 3'h5, 3'h2}, o_thresh);
        rdc(RFS_OFS_UV_WRN, 8'h3e, "uv_wrn");
    endtask
    task automatic t_warn;
        logic [7:0] d;
        logic       k;
        for (int i = 0; i < 8; i++)
        begin
            i_warn_cmp = rfs_rail_t'(8'h01 << i);
            cyc(1);
            i_warn_cmp = '0;
            chk("alert", 18'h0, 18'(o_fault_alert_n));
            host.on_alert(4, d, k);
            chk("rack", 18'h1, 18'(k));
            chk("warn_stat", 18'(8'h01 << i), 18'(d));
            chk("alert", 18'h0, 18'(o_fault_alert_n));
            chk("main_run", 18'h1, 18'(o_main_run));
            host.wr(RFS_OFS_WRN_STAT, 8'h01 << i);
            cyc(1);
            chk("alert", 18'h1, 18'(o_fault_alert_n));
        end
        // comparator still active in the clear cycle keeps its bit
        i_warn_cmp = rfs_rail_t'(8'h01);
        host.wr(RFS_OFS_WRN_STAT, 8'h01);
        i_warn_cmp = '0;
        rdc(RFS_OFS_WRN_STAT, 8'h01, "set_wins");
        host.wr(RFS_OFS_WRN_STAT, 8'h01);
    endtask
    task automatic t_hiccup;
        int n;
        for (int i = 0; i < 8; i++)
        begin
            trip(i, 1'b0);
            chk("main_run", 18'h0, 18'(o_main_run));
            chk("alert", 18'h0, 18'(o_fault_alert_n));
            pulse(1'b0, 40, n);
            chk("hiccup_len", 18'(HC), 18'(n));
            chk("aux_run", 18'h1, 18'(o_aux_run));
            chk("main_run", 18'h1, 18'(o_main_run));
            rdc(RFS_OFS_LIM_STAT, 8'h01 << i, "lim_stat");
            host.wr(RFS_OFS_LIM_STAT, 8'hff);
        end
    endtask
    task automatic t_latch;
        int n;
        trip(3, 1'b1);
        cyc(30);
        chk("main_run", 18'h0, 18'(o_main_run));
        chk("aux_run", 18'h1, 18'(o_aux_run));
        i_run_enable = 1'b0;
        cyc(2);
        i_run_enable = 1'b1;
        pulse(1'b0, 4, n);
        chk("soft_start", 18'h1, 18'(o_soft_start));
        cyc(1);
        chk("main_run", 18'h1, 18'(o_main_run));
        trip(4, 1'b1);
        i_chip_enable = 1'b0;
        cyc(2);
        chk("aux_run", 18'h0, 18'(o_aux_run));
        i_chip_enable = 1'b1;
        pulse(1'b1, 4, n);
        chk("full_init", 18'h1, 18'(o_full_init));
        cyc(1);
        chk("aux_run", 18'h1, 18'(o_aux_run));
        chk("main_run", 18'h1, 18'(o_main_run));
        host.wr(RFS_OFS_LIM_STAT, 8'hff);
    endtask
    task automatic t_override;
        int n;
        host.wr(RFS_OFS_LIM_A, 8'h01);
        host.wr(RFS_OFS_LIM_B, 8'h01);
        rdc(RFS_OFS_LIM_B, 8'h01, "lim_b");
        trip(0, 1'b0);
        pulse(1'b0, 40, n);
        chk("hiccup_len", 18'(HC), 18'(n));
        host.wr(RFS_OFS_OVR_EN, 8'h80);
        trip(0, 1'b0);
        cyc(30);
        chk("main_run", 18'h0, 18'(o_main_run));
        run_toggle;
        chk("main_run", 18'h1, 18'(o_main_run));
        host.wr(RFS_OFS_WRN_A, 8'h02);
        host.wr(RFS_OFS_WRN_B, 8'h02);
        i_warn_cmp = rfs_rail_t'(8'h02);
        cyc(1);
        i_warn_cmp = '0;
        cyc(30);
        chk("main_run", 18'h0, 18'(o_main_run));
        run_toggle;
        chk("main_run", 18'h1, 18'(o_main_run));
        // escalated warning with hiccup selected
        host.wr(RFS_OFS_WRN_B, 8'h00);
        i_warn_cmp = rfs_rail_t'(8'h02);
        cyc(1);
        i_warn_cmp = '0;
        chk("main_run", 18'h0, 18'(o_main_run));
        pulse(1'b0, 40, n);
        chk("hiccup_len", 18'(HC), 18'(n));
    endtask
    // ==========
    // clock, sequence, watchdog
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        i_sys_rst = 1'b1;
        i_warn_cmp = '0;
        i_limit_cmp = '0;
        i_mode_latch = 1'b0;
        i_run_enable = 1'b1;
        i_chip_enable = 1'b1;
        cyc(2);
        i_sys_rst = 1'b0;
        t_reset;
        t_thresh;
        t_warn;
        t_hiccup;
        t_latch;
        t_override;
        print_verdict;
    end
    // the tests need about 450 cycles
    initial
    begin
        #40000;
        err_count++;
        print_verdict;
    end
endmodule // tb_rfs_supervisor
